/* File: ebwc_cfg_mem.sv */
// Purpose: per-window configuration store, registered read
// Assumes: one write port, one read port, same clock
// Notes: entry 0 is the default window
`timescale 1ns/1ps
module ebwc_cfg_mem #(
   parameter int DEPTH = 5,
   parameter int WIDTH = 13
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // write side
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [WIDTH-1:0] rst_data_i,
   // read side
   input wire logic [2:0] rd_idx_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= rst_data_i;
         end
      end else if (wr_en_i && (int'(wr_idx_i) < DEPTH)) begin
         mem_q[wr_idx_i] <= wr_data_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rd_data_o <= rst_data_i;
      end else if (int'(rd_idx_i) < DEPTH) begin
         rd_data_o <= mem_q[rd_idx_i];
      end else begin
         rd_data_o <= mem_q[0];
      end
   end
endmodule : ebwc_cfg_mem

/* File: ebwc_ext_mem.sv */
// Purpose: external memory with ready line
// Assumes: samples on reference clock rise
// Notes: 256 words, low address bits only
`timescale 1ns/1ps
module ebwc_ext_mem (
   // from the controller
   input wire logic ref_clk_i,
   input wire logic [23:0] addr_i,
   input wire logic [15:0] ad_out_i,
   input wire logic ale_i,
   input wire logic rd_b_i,
   input wire logic wr_b_i,
   input wire logic bhe_b_i,
   input wire logic sel_b_i,
   // ready behaviour
   input wire logic rdy_pol_i,
   input wire logic [3:0] rdy_dly_i,
   // back to the controller
   output logic [15:0] ad_in_o,
   output logic ready_o
);
   logic [15:0] mem [0:255];
   logic [23:0] lat_q = 24'h000000;
   logic mux_q = 1'b0;
   logic [3:0] cnt_q = 4'h0;
   logic [15:0] last_q = 16'h0000;
   logic [23:0] a;
   assign a = mux_q ? lat_q : addr_i;
   // released lines show the inverse of the last value, never a stale copy
   assign ad_in_o = !rd_b_i ? mem[a[8:1]] : ~last_q;
   assign ready_o = (cnt_q >= rdy_dly_i) ? rdy_pol_i : ~rdy_pol_i;
   always @(posedge ref_clk_i) begin
      if (ale_i) begin
         lat_q <= {addr_i[23:16], ad_out_i};
         mux_q <= 1'b1;
      end else if (sel_b_i) begin
         mux_q <= 1'b0;
      end
      cnt_q <= (rd_b_i && wr_b_i) ? 4'h0 : cnt_q + ((cnt_q == 4'hf) ? 4'h0 : 4'h1);
      if (!rd_b_i) last_q <= ad_in_o;
      if (!wr_b_i && !bhe_b_i) mem[a[8:1]][15:8] <= ad_out_i[15:8];
      if (!wr_b_i && !a[0]) mem[a[8:1]][7:0] <= ad_out_i[7:0];
   end
endmodule : ebwc_ext_mem

/* File: ebwc_pkg.sv */
// Purpose: constants for the external bus window controller
// Assumes: 24-bit linear address, 16-bit internal data
// Notes: timing counts are in bus reference clock cycles, two mclk_i cycles each
package ebwc_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int NWIN = 4;
   localparam int SEG_W = 8;
   localparam int PAGE_W = 2;
   localparam int OFS_W = 14;
   // window_function_config field positions
   localparam int FC_EN = 0;
   localparam int FC_MUX = 1;
   localparam int FC_BUS16 = 2;
   localparam int FC_RDY_EN = 3;
   localparam int FC_RDY_POL = 4;
   localparam int FC_W = 5;
   // window_timing_config field positions
   localparam int TC_ALE_LSB = 0;
   localparam int TC_ALE_W = 2;
   localparam int TC_WAIT_LSB = 2;
   localparam int TC_WAIT_W = 4;
   localparam int TC_HOLD_LSB = 6;
   localparam int TC_HOLD_W = 2;
   localparam int TC_W = 8;
   // window_address_select: base in [15:4] for address bits [23:12], size code in [3:0]
   localparam int AS_BASE_LSB = 12;
   localparam int AS_SIZE_W = 4;
   localparam int AS_W = 16;
   // external I/O area
   localparam logic [23:0] IO_LO = 24'h210000;
   localparam logic [23:0] IO_HI = 24'h3fffff;
   // system segment, served on chip
   localparam logic [7:0] SYS_SEG = 8'h00;
   // internal peripheral bus area
   localparam logic [23:0] PB_LO = 24'h200000;
   localparam logic [23:0] PB_HI = 24'h20ffff;
   localparam logic [4:0] MAX_ADDR_BITS = 5'h18;
   localparam logic [2:0] SEG_SEL_MAX = 3'h7;
   localparam logic [1:0] RST_ALE = 2'h1;
   localparam logic [3:0] RST_WAIT = 4'h3;
   localparam logic [1:0] RST_HOLD = 2'h1;
   localparam int PHASE_CNT_W = 4;
   typedef enum logic [2:0] {
      EBWC_IDLE = 3'b000,
      EBWC_ADDR = 3'b001,
      EBWC_DATA = 3'b011,
      EBWC_WAIT = 3'b010,
      EBWC_HOLD = 3'b110,
      EBWC_DONE = 3'b111
   } ebwc_state_t;
endpackage : ebwc_pkg

/* File: ebwc_props.sv */
// Purpose: port checks for ebwc_top
// Assumes: one request at a time
// Notes: bound at the foot, top ports only
`timescale 1ns/1ps
module ebwc_props
   import ebwc_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // request side
   input wire logic ext_mode_i,
   input wire logic req_i,
   input wire logic spec_i,
   input wire logic [ebwc_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic ack_o,
   // pins
   input wire logic bus_reference_clock_out_o,
   input wire logic ale_o,
   input wire logic rd_b_o,
   input wire logic wr_b_o,
   input wire logic [ebwc_pkg::NWIN:0] cs_b_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   // a speculative request into the i/o area must stall
   wire logic io_spec = req_i && spec_i && (req_addr_i >= IO_LO) && (req_addr_i <= IO_HI);
   property p_cs_one;
      $onehot0(~cs_b_o);
   endproperty
   a_cs_one: assert property (p_cs_one) else $error("two selects low");
   property p_strobe_cs;
      (!rd_b_o || !wr_b_o) |-> !(&cs_b_o);
   endproperty
   a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
   property p_rdwr;
      !(!rd_b_o && !wr_b_o);
   endproperty
   a_rdwr: assert property (p_rdwr) else $error("read and write strobes together");
   property p_ale_first;
      $rose(ale_o) |-> rd_b_o && wr_b_o;
   endproperty
   a_ale_first: assert property (p_ale_first) else $error("latch strobe during data");
   property p_single;
      !ext_mode_i |-> &cs_b_o;
   endproperty
   a_single: assert property (p_single) else $error("select in single chip mode");
   property p_io_spec;
      io_spec [*3] |-> !ack_o;
   endproperty
   a_io_spec: assert property (p_io_spec) else $error("speculative i/o access served");
   property p_refclk;
      $past(rst_b_i) |-> bus_reference_clock_out_o != $past(bus_reference_clock_out_o);
   endproperty
   a_refclk: assert property (p_refclk) else $error("reference clock stalled");
   property p_ack;
      ack_o |=> !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule : ebwc_props
bind ebwc_top ebwc_props u_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ext_mode_i(ext_mode_i), .req_i(req_i),
   .spec_i(spec_i), .req_addr_i(req_addr_i), .ack_o(ack_o), .bus_reference_clock_out_o(bus_reference_clock_out_o),
   .ale_o(ale_o), .rd_b_o(rd_b_o), .wr_b_o(wr_b_o), .cs_b_o(cs_b_o));

/* File: ebwc_top.sv */
// Purpose: external bus window controller, access request to external bus cycle
// Assumes: one request at a time; requester holds req until ack
// Notes: bus_reference_clock_out is mclk_i divided by two, outputs change on its rise as well as on its fall
// Notes on behaviour
// R1 - 256 segments of 64K, four 16K pages
// R2 - byte and word accesses everywhere
// R3 - reserved areas go to external bus
// R4 - I/O area accesses strictly ordered, no speculation
// R5 - single-chip mode or external bus mode
// R6 - driven address bits programmable 0 to 24
// R7 - data width 8 or 16 bits
// R8 - muxed or demuxed; demuxed uses own address lines
// R9 - segment lines selectable, 64K up to 8M
// R10 - active-low select per window plus default
// R11 - per-window timing and function configuration
// R12 - ready input extends cycle, polarity programmable
// R13 - four programmable address windows
// R14 - window 4 over 3, window 2 over 1
// R15 - uncovered accesses use default window settings
// R16 - bus timing referenced to reference clock rise; here outputs change on its rise and on its fall
// R17 - bus mode switched per access automatically
// R18 - internal peripheral bus served the same way
// R19 - reference clock is system clock on pin; here mclk_i divided by two
// R20 - muxed: address with latch strobe, then data
`timescale 1ns/1ps
module ebwc_top
   import ebwc_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // global configuration
   input wire logic ext_mode_i,
   input wire logic [4:0] addr_bits_i,
   input wire logic [2:0] seg_sel_i,
   // window configuration write port
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_idx_i,
   input wire logic [ebwc_pkg::TC_W-1:0] cfg_timing_i,
   input wire logic [ebwc_pkg::FC_W-1:0] cfg_function_i,
   input wire logic [ebwc_pkg::AS_W-1:0] cfg_addr_sel_i,
   // access request from the fetch and transfer units
   input wire logic req_i,
   input wire logic req_we_i,
   input wire logic req_byte_i,
   input wire logic [ebwc_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [ebwc_pkg::DATA_W-1:0] req_wdata_i,
   input wire logic spec_i,
   output logic ack_o,
   output logic [ebwc_pkg::DATA_W-1:0] rdata_o,
   output logic onchip_o,
   output logic io_area_o,
   // internal peripheral bus
   output logic pb_sel_o,
   input wire logic pb_ready_i,
   input wire logic [ebwc_pkg::DATA_W-1:0] pb_rdata_i,
   // external pins
   output logic bus_reference_clock_out_o,
   output logic [ebwc_pkg::ADDR_W-1:0] addr_o,
   output logic [ebwc_pkg::ADDR_W-1:0] addr_oe_o,
   output logic [ebwc_pkg::DATA_W-1:0] ad_o,
   output logic ad_oe_o,
   input wire logic [ebwc_pkg::DATA_W-1:0] ad_i,
   output logic ale_o,
   output logic rd_b_o,
   output logic wr_b_o,
   output logic bhe_b_o,
   output logic [ebwc_pkg::NWIN:0] cs_b_o,
   input wire logic ready_pin_i
);
   localparam int CFG_W = TC_W + FC_W;

   ebwc_state_t state_q;
   logic ready_s1_q, ready_s2_q;
   logic [AS_W-1:0] asel_q [1:NWIN];
   logic [2:0] win_q;
   logic [PHASE_CNT_W-1:0] cnt_q;
   logic clk_div_q;
   logic [CFG_W-1:0] cfg_rd;
   logic [ADDR_W-1:0] addr_q;
   logic we_q, byte_q, pb_q, odd_hi_q;
   logic [DATA_W-1:0] wdata_q;
   logic [2:0] win_d;
   logic in_pb, in_sys, in_io, tick;
   logic [TC_W-1:0] tc;
   logic [FC_W-1:0] fc;
   logic ready_act;
   logic [ADDR_W-1:0] addr_prev_q;

   // address hit test: base aligned to the 4K granule times 2^size
   function automatic logic win_hit(input logic [AS_W-1:0] sel, input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] mask;
      logic [ADDR_W-1:0] base;
      mask = ~((24'h001000 << sel[AS_SIZE_W-1:0]) - 24'h000001);
      base = {sel[AS_W-1:AS_SIZE_W], 12'h000};
      win_hit = ((a & mask) == (base & mask));
   endfunction : win_hit

   function automatic logic [ADDR_W-1:0] addr_mask(input logic [4:0] nbits, input logic [2:0] seg);
      logic [ADDR_W-1:0] m;
      m = (nbits >= MAX_ADDR_BITS) ? 24'hffffff : ((24'h000001 << nbits) - 24'h000001);
      // segment lines from 16 + seg upward freed for other use; seg 7 keeps 23 bits = 8 Mbytes
      m = m & ((24'h010000 << seg) - 24'h000001); // R9
      addr_mask = m; // R6
   endfunction : addr_mask

   // address decode of the 24-bit space: segment [23:16], page [15:14]
   assign in_sys = (req_addr_i[ADDR_W-1 -: SEG_W] == SYS_SEG); // R1
   assign in_pb = (req_addr_i >= PB_LO) && (req_addr_i <= PB_HI); // R18
   assign in_io = (req_addr_i >= IO_LO) && (req_addr_i <= IO_HI);

   // window priority 4 over 3, 2 over 1, fall back to default 0
   always_comb begin
      win_d = 3'h0; // R15
      for (int w = 1; w <= NWIN; w++) begin
         if (asel_q[w][AS_W-1:AS_SIZE_W] != 12'h000 && win_hit(asel_q[w], req_addr_i)) begin
            win_d = 3'(w); // R14
         end
      end
   end

   // window address select registers
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         for (int w = 1; w <= NWIN; w++) begin
            asel_q[w] <= 16'h0000;
         end
      end else if (cfg_wr_i && cfg_idx_i != 3'h0 && int'(cfg_idx_i) <= NWIN) begin
         asel_q[cfg_idx_i] <= cfg_addr_sel_i; // R13
      end
   end

   ebwc_cfg_mem #(
      .DEPTH(NWIN + 1),
      .WIDTH(CFG_W)
   ) u_cfg (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(cfg_wr_i),
      .wr_idx_i(cfg_idx_i),
      .wr_data_i({cfg_timing_i, cfg_function_i}),
      .rst_data_i({RST_HOLD, RST_WAIT, RST_ALE, 5'h07}),
      .rd_idx_i(win_d),
      .rd_data_o(cfg_rd)
   ); // R11

   assign tc = cfg_rd[CFG_W-1:FC_W];
   assign fc = cfg_rd[FC_W-1:0];
   // polarity chosen per window
   assign ready_act = (ready_s2_q == fc[FC_RDY_POL]) || !fc[FC_RDY_EN]; // R12

   // ready pin synchroniser
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         ready_s1_q <= 1'b0;
         ready_s2_q <= 1'b0;
      end else begin
         ready_s1_q <= ready_pin_i;
         ready_s2_q <= ready_s1_q;
      end
   end

   // last cycle's address: the registered config read matches only once it held still
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         addr_prev_q <= '0;
      end else begin
         addr_prev_q <= req_addr_i;
      end
   end

   // reference clock: high while tick is high, pins follow state_q one edge later, so on tick and non-tick edges
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         clk_div_q <= 1'b0;
      end else begin
         clk_div_q <= !clk_div_q;
      end
   end
   assign tick = clk_div_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bus_reference_clock_out_o <= 1'b0;
      end else begin
         bus_reference_clock_out_o <= !clk_div_q; // R19 R16
      end
   end

   // sequencer; pb path and onchip decisions taken in IDLE
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_q <= EBWC_IDLE;
         cnt_q <= '0;
         win_q <= 3'h0;
         addr_q <= '0;
         we_q <= 1'b0;
         byte_q <= 1'b0;
         pb_q <= 1'b0;
         odd_hi_q <= 1'b0;
         wdata_q <= '0;
      end else begin
         unique case (state_q)
            EBWC_IDLE: begin
               // wait for the registered config read of this address, and for spec to drop in I/O
               if (req_i && !ack_o && !onchip_o && tick && !(in_io && spec_i) && !(in_sys && !in_pb)
                   && (ext_mode_i || in_pb) && (req_addr_i == addr_prev_q)) begin // R4 R5 R3
                  state_q <= EBWC_ADDR;
                  win_q <= win_d;
                  addr_q <= req_addr_i;
                  we_q <= req_we_i;
                  byte_q <= req_byte_i; // R2
                  pb_q <= in_pb;
                  wdata_q <= req_wdata_i;
                  odd_hi_q <= req_addr_i[0];
                  cnt_q <= PHASE_CNT_W'(tc[TC_ALE_LSB +: TC_ALE_W]);
               end
            end
            EBWC_ADDR: begin
               if (cnt_q == '0) begin
                  state_q <= EBWC_DATA;
                  cnt_q <= tc[TC_WAIT_LSB +: TC_WAIT_W];
               end else if (tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            EBWC_DATA: begin
               if (cnt_q == '0) begin
                  state_q <= EBWC_WAIT;
               end else if (tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            EBWC_WAIT: begin
               if (pb_q ? pb_ready_i : (tick && ready_act)) begin // R12 R18
                  state_q <= EBWC_HOLD;
                  cnt_q <= PHASE_CNT_W'(tc[TC_HOLD_LSB +: TC_HOLD_W]);
               end
            end
            EBWC_HOLD: begin
               if (cnt_q == '0) begin
                  state_q <= EBWC_DONE;
               end else if (tick) begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            EBWC_DONE: begin
               state_q <= EBWC_IDLE;
            end
            default: begin
               state_q <= EBWC_IDLE;
            end
         endcase
      end
   end

   // answer to the requester
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         ack_o <= 1'b0;
         rdata_o <= '0;
         onchip_o <= 1'b0;
         io_area_o <= 1'b0;
      end else begin
         ack_o <= (state_q == EBWC_DONE) || (state_q == EBWC_IDLE && req_i && !ack_o && !onchip_o
                  && ((in_sys && !in_pb) || (!ext_mode_i && !in_pb)));
         // on-chip targets get a one-cycle refusal flag so the on-chip units answer
         onchip_o <= state_q == EBWC_IDLE && req_i && !ack_o && !onchip_o
                     && ((in_sys && !in_pb) || (!ext_mode_i && !in_pb)); // R5
         io_area_o <= in_io && req_i; // R4
         if (state_q == EBWC_WAIT) begin
            if (pb_q) begin
               rdata_o <= pb_rdata_i;
            end else if (!fc[FC_BUS16] || byte_q) begin
               // 8-bit bus or byte read: byte lands in the low lane
               rdata_o <= {8'h00, (fc[FC_BUS16] && odd_hi_q) ? ad_i[15:8] : ad_i[7:0]}; // R7
            end else begin
               rdata_o <= ad_i;
            end
         end
      end
   end

   // pin drive, each access uses its own window mode
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pb_sel_o <= 1'b0;
         addr_o <= '0;
         addr_oe_o <= '0;
         ad_o <= '0;
         ad_oe_o <= 1'b0;
         ale_o <= 1'b0;
         rd_b_o <= 1'b1;
         wr_b_o <= 1'b1;
         bhe_b_o <= 1'b1;
         cs_b_o <= '1;
      end else begin
         pb_sel_o <= (state_q != EBWC_IDLE) && (state_q != EBWC_DONE) && pb_q; // R18
         addr_oe_o <= ext_mode_i ? addr_mask(addr_bits_i, seg_sel_i) : '0; // R6 R9
         if (state_q == EBWC_ADDR && !pb_q) begin
            addr_o <= addr_q & addr_mask(addr_bits_i, seg_sel_i);
            cs_b_o <= ~((NWIN+1)'(1) << win_q); // R10
            bhe_b_o <= !(fc[FC_BUS16] && (!byte_q || odd_hi_q));
            if (fc[FC_MUX]) begin
               ad_o <= addr_q[DATA_W-1:0]; // R8 R20 R17
               ad_oe_o <= 1'b1;
               ale_o <= 1'b1; // R20
            end else begin
               ad_oe_o <= 1'b0;
               ale_o <= 1'b0; // R8
            end
         end else if ((state_q == EBWC_DATA || state_q == EBWC_WAIT) && !pb_q) begin
            ale_o <= 1'b0;
            rd_b_o <= we_q;
            wr_b_o <= !we_q;
            ad_oe_o <= we_q; // R20
            // byte writes replicate the byte on both lanes
            ad_o <= byte_q ? {wdata_q[7:0], wdata_q[7:0]} : wdata_q;
         end else if (state_q == EBWC_HOLD || state_q == EBWC_DONE) begin
            rd_b_o <= 1'b1;
            wr_b_o <= 1'b1;
            ad_oe_o <= 1'b0;
            ale_o <= 1'b0;
            if (state_q == EBWC_DONE) begin
               cs_b_o <= '1;
               bhe_b_o <= 1'b1;
            end
         end
      end
   end
endmodule : ebwc_top

/* File: testbench.sv */
// Purpose: self-checking bench for ebwc_top
// Assumes: inputs change on the falling edge
// Notes: external memory model behind the pins
`timescale 1ns/1ps
module testbench;
   import ebwc_pkg::*;
   logic mclk_i = 1'b0, rst_b_i = 1'b0, ext_mode_i = 1'b1, cfg_wr_i = 1'b0, req_i = 1'b0, req_we_i = 1'b0;
   logic req_byte_i = 1'b0, spec_i = 1'b0, pb_ready_i = 1'b0, rdy_pol = 1'b0, ack_o, onchip_o, ale_o, rclk;
   logic rd_b_o, wr_b_o, bhe_b_o, ready_pin_i, ale_seen, io_area_o, pb_sel_o, ad_oe_o, doe_seen;
   logic [1:0] flg;
   logic [4:0] addr_bits_i = 5'h18;
   logic [2:0] seg_sel_i = 3'h7, cfg_idx_i = 3'h0;
   logic [7:0] cfg_timing_i = 8'h00;
   logic [4:0] cfg_function_i = 5'h00;
   logic [15:0] cfg_addr_sel_i = 16'h0000, req_wdata_i = 16'h0000, rdata_o, pb_rdata_i, ad_o, ad_i, got;
   logic [23:0] req_addr_i = 24'h000000, addr_o, addr_oe_o, oe_seen;
   logic [4:0] cs_b_o, cs_acc;
   logic [3:0] rdy_dly = 4'h0;
   int errors = 0, comparisons = 0, n_acc, fast;
   always #25 mclk_i = ~mclk_i;
   assign pb_rdata_i = pb_sel_o ? 16'hbeef : 16'h4110;
   always @(negedge mclk_i) pb_ready_i <= pb_sel_o;
   // sampled away from the launching edge so the accumulators see settled pins
   always @(negedge mclk_i) begin
      cs_acc &= cs_b_o;
      ale_seen |= ale_o;
      oe_seen |= addr_oe_o;
      doe_seen |= ad_oe_o;
   end
   ebwc_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ext_mode_i(ext_mode_i), .addr_bits_i(addr_bits_i),
      .seg_sel_i(seg_sel_i), .cfg_wr_i(cfg_wr_i), .cfg_idx_i(cfg_idx_i), .cfg_timing_i(cfg_timing_i),
      .cfg_function_i(cfg_function_i), .cfg_addr_sel_i(cfg_addr_sel_i), .req_i(req_i), .req_we_i(req_we_i),
      .req_byte_i(req_byte_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .spec_i(spec_i),
      .ack_o(ack_o), .rdata_o(rdata_o), .onchip_o(onchip_o), .io_area_o(io_area_o), .pb_sel_o(pb_sel_o),
      .pb_ready_i(pb_ready_i), .pb_rdata_i(pb_rdata_i), .bus_reference_clock_out_o(rclk), .addr_o(addr_o),
      .addr_oe_o(addr_oe_o), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .ad_i(ad_i), .ale_o(ale_o), .rd_b_o(rd_b_o),
      .wr_b_o(wr_b_o), .bhe_b_o(bhe_b_o), .cs_b_o(cs_b_o), .ready_pin_i(ready_pin_i));
   ebwc_ext_mem u_mem (.ref_clk_i(rclk), .addr_i(addr_o), .ad_out_i(ad_o), .ale_i(ale_o), .rd_b_i(rd_b_o),
      .wr_b_i(wr_b_o), .bhe_b_i(bhe_b_o), .sel_b_i(&cs_b_o), .rdy_pol_i(rdy_pol), .rdy_dly_i(rdy_dly),
      .ad_in_o(ad_i), .ready_o(ready_pin_i));
   task automatic print_verdict();
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic cfg(input logic [2:0] idx, input logic [7:0] t, input logic [4:0] f, input logic [15:0] s);
      @(negedge mclk_i);
      cfg_wr_i = 1'b1;
      cfg_idx_i = idx;
      cfg_timing_i = t;
      cfg_function_i = f;
      cfg_addr_sel_i = s;
      @(negedge mclk_i);
      cfg_wr_i = 1'b0;
   endtask : cfg
   // the request is held until ack; config settles three cycles first
   task automatic acc(input logic we, input logic byt, input logic [23:0] a, input logic [15:0] wd, input logic sp);
      repeat (3) @(negedge mclk_i);
      cs_acc = 5'h1f;
      ale_seen = 1'b0;
      oe_seen = 24'h000000;
      doe_seen = 1'b0;
      {req_i, req_we_i, req_byte_i, req_addr_i, req_wdata_i, spec_i} = {1'b1, we, byt, a, wd, sp};
      if (sp) begin
         repeat (20) begin
            @(negedge mclk_i);
            chk("spec_stall", 24'h0, 24'(ack_o));
         end
         spec_i = 1'b0;
      end
      n_acc = 0;
      while (ack_o !== 1'b1 && n_acc < 400) begin
         @(negedge mclk_i);
         n_acc++;
      end
      if (n_acc >= 400) begin
         errors++;
         print_verdict();
      end
      got = rdata_o;
      flg = {onchip_o, io_area_o};
      req_i = 1'b0;
   endtask : acc
   task automatic lim(input logic [4:0] b, input logic [2:0] s, input logic [23:0] m);
      addr_bits_i = b;
      seg_sel_i = s;
      acc(1'b0, 1'b0, 24'h500020, 16'h0000, 1'b0);
      chk("addr_mask", m, oe_seen);
   endtask : lim
   initial begin
      repeat (6) @(negedge mclk_i);
      rst_b_i = 1'b1;
      @(negedge mclk_i);
      chk("cs_reset", 24'h1f, 24'(cs_b_o));
      cfg(3'h1, 8'h4d, 5'h07, 16'h4104);
      cfg(3'h2, 8'h4d, 5'h07, 16'h4100);
      cfg(3'h3, 8'h4d, 5'h05, 16'h5000);
      cfg(3'h4, 8'h4d, 5'h0d, 16'h5000);
      acc(1'b1, 1'b0, 24'h400010, 16'h1234, 1'b0);
      chk("cs_default", 24'h1e, 24'(cs_acc));
      chk("ale_mux", 24'h1, 24'(ale_seen));
      chk("ad_oe_write", 24'h1, 24'(doe_seen));
      acc(1'b1, 1'b1, 24'h400011, 16'h005a, 1'b0);
      acc(1'b0, 1'b0, 24'h400010, 16'h0000, 1'b0);
      chk("byte_lane", 24'h5a34, 24'(got));
      acc(1'b0, 1'b1, 24'h400011, 16'h0000, 1'b0);
      chk("byte_hi_lane", 24'h5a, 24'(got));
      acc(1'b1, 1'b0, 24'h410000, 16'h2222, 1'b0);
      chk("cs_win2", 24'h1b, 24'(cs_acc));
      acc(1'b1, 1'b0, 24'h418000, 16'h3333, 1'b0);
      chk("cs_win1", 24'h1d, 24'(cs_acc));
      cfg(3'h2, 8'h4d, 5'h03, 16'h4100);
      acc(1'b0, 1'b0, 24'h410000, 16'h0000, 1'b0);
      chk("bus8_read", 24'h33, 24'(got));
      acc(1'b1, 1'b0, 24'h500020, 16'h4321, 1'b0);
      chk("cs_win4", 24'h0f, 24'(cs_acc));
      chk("ale_demux", 24'h0, 24'(ale_seen));
      fast = n_acc;
      for (int p = 0; p < 2; p++) begin
         cfg(3'h4, 8'h4d, p[0] ? 5'h1d : 5'h0d, 16'h5000);
         rdy_pol = p[0];
         rdy_dly = 4'hc;
         acc(1'b0, 1'b0, 24'h500020, 16'h0000, 1'b0);
         chk("rdy_data", 24'h4321, 24'(got));
         chk("rdy_stretch", 24'h1, 24'(n_acc >= fast + 10));
         chk("ad_oe_read", 24'h0, 24'(doe_seen));
      end
      rdy_dly = 4'h0;
      lim(5'h18, 3'h7, 24'h7fffff);
      lim(5'h18, 3'h0, 24'h00ffff);
      lim(5'h08, 3'h7, 24'h0000ff);
      acc(1'b0, 1'b0, 24'hf00000, 16'h0000, 1'b0);
      chk("reserved_ext", 24'h1e, 24'(cs_acc));
      chk("reserved_flags", 24'h0, 24'(flg));
      acc(1'b0, 1'b0, 24'h008000, 16'h0000, 1'b0);
      chk("seg0_cs", 24'h1f, 24'(cs_acc));
      chk("seg0_flags", 24'h2, 24'(flg));
      acc(1'b0, 1'b0, 24'h200040, 16'h0000, 1'b0);
      chk("pb_data", 24'hbeef, 24'(got));
      chk("pb_cs", 24'h1f, 24'(cs_acc));
      acc(1'b0, 1'b0, 24'h300000, 16'h0000, 1'b1);
      chk("io_cs", 24'h1e, 24'(cs_acc));
      chk("io_flags", 24'h1, 24'(flg));
      ext_mode_i = 1'b0;
      acc(1'b0, 1'b0, 24'h400010, 16'h0000, 1'b0);
      chk("single_cs", 24'h1f, 24'(cs_acc));
      chk("single_flags", 24'h2, 24'(flg));
      print_verdict();
   end
endmodule : testbench
